// *** dv/card_host_model.sv ***
/*
 Host controller model: issues commands and status polls to the card.
 Assumes the bench calls its tasks and sys_clk_i runs at 100 MHz.
*/
`timescale 1ns/100ps
module card_host_model
	import card_status_pkg::*;
(
	input  wire logic sys_clk_i,
	output cmd_evt_t  cmd_o,
	output logic      status_read_o
);
	// ************************************************************
	// Command issue
	// ************************************************************
	initial begin
		cmd_o         = '0;
		status_read_o = 1'b0;
	end

	// Fields are scrambled after the pulse so stale values cannot help
	task automatic send_cmd(input logic [5:0] idx, input logic crc,
		input logic ill, input logic rd);
		@(posedge sys_clk_i);
		#1;
		cmd_o         = cmd_evt_t'({1'b1, crc, ill, idx});
		status_read_o = rd;
		@(posedge sys_clk_i);
		#1;
		cmd_o         = cmd_evt_t'({1'b0, ~crc, ~ill, ~idx});
		status_read_o = 1'b0;
	endtask

	// A status poll raises status_read_o, which clears the clear-by-read flags
	task automatic poll_status();
		send_cmd(CMD_SEND_STATUS, 1'b0, 1'b0, 1'b1);
	endtask
endmodule

// *** dv/memory_card_status_word_bench.sv ***
/*
 Self-checking bench for the card status word block.
 Assumes the host model drives commands and the bench drives events.
*/
`timescale 1ns/100ps
module memory_card_status_word_bench
	import card_status_pkg::*;
;
	logic        sys_clk;
	logic        nrst;
	cmd_evt_t    cmd_w;
	fault_evt_t  fault_w;
	cond_t       cond_w;
	logic        status_read_w;
	logic [31:0] status_w;
	int          error_cnt;
	int          tests_run;

	memory_card_status_word memory_card_status_word_inst (
		.sys_clk_i     (sys_clk),
		.nrst_i        (nrst),
		.cmd_i         (cmd_w),
		.fault_i       (fault_w),
		.cond_i        (cond_w),
		.status_read_i (status_read_w),
		.status_o      (status_w)
	);

	card_host_model card_host_model_inst (
		.sys_clk_i     (sys_clk),
		.cmd_o         (cmd_w),
		.status_read_o (status_read_w)
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	task automatic check(input logic [31:0] exp);
		tests_run++;
		if (status_w !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: exp %h got %h", $time, exp,
				status_w);
		end
	endtask

	task automatic wait_edges(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic pulse_fault(input int i);
		@(posedge sys_clk);
		#1;
		fault_w = fault_evt_t'(12'h800 >> i);
		@(posedge sys_clk);
		#1;
		fault_w = '0;
	endtask

	task automatic conclude();
		$display("checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic flags_read_clear();
		int pos[12];
		pos = '{BIT_ADDR_RANGE, BIT_BLOCK_ALIGN, BIT_BLOCKLEN,
			BIT_ERASE_ORDER, BIT_ERASE_GROUP, BIT_PROT_WRITE, BIT_LOCK_FAIL,
			BIT_ECC_FAIL, BIT_INTERNAL_CTRL, BIT_GENERIC, BIT_ID_OVERWRITE,
			BIT_ERASE_SKIP};
		for (int i = 0; i < 12; i++) begin
			pulse_fault(i);
			check(32'h00000000);
			wait_edges(1);
			check(32'h00000001 << pos[i]);
			wait_edges(3);
			check(32'h00000001 << pos[i]);
			card_host_model_inst.poll_status();
			wait_edges(1);
			check(32'h00000000);
		end
	endtask

	task automatic mirror_cond();
		cond_w = cond_t'(2'b10);
		wait_edges(1);
		check(32'h00000001 << BIT_LOCKED);
		cond_w = cond_t'(2'b01);
		wait_edges(1);
		check(32'h00000001 << BIT_ECC_OFF);
		cond_w = '0;
		wait_edges(1);
		check(32'h00000000);
	endtask

	// Successive commands, idle cycles between: each flag speaks of the latest command
	task automatic per_command();
		card_host_model_inst.send_cmd(6'h11, 1'b0, 1'b1, 1'b0);
		wait_edges(1);
		check(32'h00000001 << BIT_ILLEGAL_CMD);
		card_host_model_inst.send_cmd(6'h11, 1'b1, 1'b0, 1'b0);
		wait_edges(1);
		check(32'h00000001 << BIT_CMD_CRC);
		wait_edges(3);
		check(32'h00000001 << BIT_CMD_CRC);
		card_host_model_inst.send_cmd(6'h11, 1'b0, 1'b0, 1'b0);
		wait_edges(1);
		check(32'h00000000);
	endtask

	task automatic erase_cancel();
		card_host_model_inst.send_cmd(CMD_ERASE_START, 1'b0, 1'b0, 1'b0);
		card_host_model_inst.poll_status();
		wait_edges(2);
		check(32'h00000000);
		card_host_model_inst.send_cmd(6'h11, 1'b0, 1'b0, 1'b0);
		wait_edges(2);
		check(32'h00000001 << BIT_ERASE_CANCEL);
		card_host_model_inst.poll_status();
		wait_edges(1);
		check(32'h00000000);
		card_host_model_inst.send_cmd(CMD_ERASE_START, 1'b0, 1'b0, 1'b0);
		card_host_model_inst.send_cmd(CMD_ERASE_END, 1'b0, 1'b0, 1'b0);
		card_host_model_inst.send_cmd(CMD_ERASE_RUN, 1'b0, 1'b0, 1'b0);
		card_host_model_inst.send_cmd(6'h11, 1'b0, 1'b0, 1'b0);
		wait_edges(2);
		check(32'h00000000);
		card_host_model_inst.send_cmd(CMD_ERASE_START, 1'b0, 1'b0, 1'b0);
		card_host_model_inst.send_cmd(6'h11, 1'b0, 1'b0, 1'b0);
		wait_edges(2);
		check(32'h00000001 << BIT_ERASE_CANCEL);
		card_host_model_inst.poll_status();
		wait_edges(1);
		check(32'h00000000);
	endtask

	// A second reset mid-run must drop latched flags at once
	task automatic reset_mid_run();
		pulse_fault(9);
		wait_edges(1);
		check(32'h00000001 << BIT_GENERIC);
		nrst = 1'b0;
		#1;
		check(STATUS_RST);
		wait_edges(2);
		nrst = 1'b1;
		wait_edges(1);
		check(STATUS_RST);
		pulse_fault(0);
		check(STATUS_RST);
		wait_edges(1);
		check(32'h00000001 << BIT_ADDR_RANGE);
	endtask

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		fault_w   = '0;
		cond_w    = '0;
		nrst      = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		repeat (12) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		check(STATUS_RST);
		flags_read_clear();
		mirror_cond();
		per_command();
		erase_cancel();
		reset_mid_run();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		conclude();
	end
endmodule

// *** src/card_status_pkg.sv ***
/*
 Package for the card status word block: bit positions, reset values,
 event and condition carrier structs and command index constants.
 Assumes a single 100 MHz command clock domain.
*/
package card_status_pkg;

	// ************************************************************
	// Status word layout
	// ************************************************************
	localparam int STATUS_W           = 32;
	localparam int BIT_ADDR_RANGE     = 31;
	localparam int BIT_BLOCK_ALIGN    = 30;
	localparam int BIT_BLOCKLEN       = 29;
	localparam int BIT_ERASE_ORDER    = 28;
	localparam int BIT_ERASE_GROUP    = 27;
	localparam int BIT_PROT_WRITE     = 26;
	localparam int BIT_LOCKED         = 25;
	localparam int BIT_LOCK_FAIL      = 24;
	localparam int BIT_CMD_CRC        = 23;
	localparam int BIT_ILLEGAL_CMD    = 22;
	localparam int BIT_ECC_FAIL       = 21;
	localparam int BIT_INTERNAL_CTRL  = 20;
	localparam int BIT_GENERIC        = 19;
	localparam int BIT_RSVD_HI        = 18;
	localparam int BIT_RSVD_LO        = 17;
	localparam int BIT_ID_OVERWRITE   = 16;
	localparam int BIT_ERASE_SKIP     = 15;
	localparam int BIT_ECC_OFF        = 14;
	localparam int BIT_ERASE_CANCEL   = 13;
	localparam int FLAG_LSB           = 13;
	localparam int FLAG_W             = 19;

	// Clear-by-read flags, set by events, relative to FLAG_LSB
	localparam logic [18:0] READ_CLR_MASK = 19'h7e9cd;
	// Reset values
	localparam logic [18:0] FLAGS_RST     = 19'h00000;
	localparam logic [31:0] STATUS_RST    = 32'h00000000;

	// ************************************************************
	// Command indices that keep an erase sequence alive
	// ************************************************************
	localparam logic [5:0] CMD_SEND_STATUS  = 6'h0d;
	localparam logic [5:0] CMD_ERASE_START  = 6'h23;
	localparam logic [5:0] CMD_ERASE_END    = 6'h24;
	localparam logic [5:0] CMD_ERASE_RUN    = 6'h26;

	// Fault events raised by the card core, one-cycle pulses
	typedef struct packed {
		logic addr_range_fault;
		logic block_alignment_fault;
		logic blocklen_fault;
		logic erase_order_fault;
		logic erase_group_fault;
		logic protected_write_fault;
		logic lock_unlock_fault;
		logic ecc_fail;
		logic internal_ctrl_fault;
		logic generic_fault;
		logic id_reg_overwrite_fault;
		logic erase_skip;
	} fault_evt_t;

	// Present conditions that the word mirrors
	typedef struct packed {
		logic locked_flag;
		logic ecc_off;
	} cond_t;

	// A received command as seen by the front end
	typedef struct packed {
		logic       valid;
		logic       crc_bad;
		logic       illegal;
		logic [5:0] index;
	} cmd_evt_t;

endpackage

// *** src/erase_cancel_detect.sv ***
/*
 Detects an erase sequence dropped by an unrelated command.
 Assumes command events arrive as one-cycle pulses on sys_clk_i.
*/
`timescale 1ns/100ps
module erase_cancel_detect
	import card_status_pkg::*;
(
	input  wire logic     sys_clk_i,
	input  wire logic     nrst_i,
	input  wire cmd_evt_t cmd_i,
	output logic          cancel_o
);

	logic pending_reg;
	logic pending_next;
	logic cancel_reg;
	wire  erase_start = cmd_i.valid && !cmd_i.illegal &&
		(cmd_i.index == CMD_ERASE_START);
	wire  erase_done  = cmd_i.valid && (cmd_i.index == CMD_ERASE_RUN);
	wire  keeps_seq   = (cmd_i.index == CMD_ERASE_START) ||
		(cmd_i.index == CMD_ERASE_END) ||
		(cmd_i.index == CMD_ERASE_RUN) ||
		(cmd_i.index == CMD_SEND_STATUS);
	wire  breaks_seq  = cmd_i.valid && pending_reg && !keeps_seq;

	assign pending_next = erase_start ? 1'b1 :
		(erase_done || breaks_seq) ? 1'b0 : pending_reg;
	assign cancel_o = cancel_reg;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pending_reg <= 1'b0;
			cancel_reg  <= 1'b0;
		end else begin
			pending_reg <= pending_next;
			cancel_reg  <= breaks_seq;
		end
	end

endmodule

// *** src/memory_card_status_word.sv ***
/*
 Status word register bank of the memory card: latches fault events,
 mirrors present conditions, and applies the three clear policies.
 Assumes a card core that pulses events on sys_clk_i and a response
 builder that samples status_o on a response strobe.
*/
`timescale 1ns/100ps
module memory_card_status_word
	import card_status_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire cmd_evt_t   cmd_i,
	input  wire fault_evt_t fault_i,
	input  wire cond_t      cond_i,
	input  wire logic       status_read_i,
	output logic [31:0]     status_o
);

	// ************************************************************
	// Event collection
	// ************************************************************
	logic              cancel;
	logic [FLAG_W-1:0] flags_reg;
	logic [FLAG_W-1:0] flags_next;
	logic [FLAG_W-1:0] set_vec;
	logic              crc_reg;
	logic              crc_next;
	logic              ill_reg;
	logic              ill_next;
	logic [31:0]       status_reg;
	logic [31:0]       status_next;

	erase_cancel_detect u_cancel (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.cmd_i     (cmd_i),
		.cancel_o  (cancel)
	);

	// Bits mapped relative to FLAG_LSB
	assign set_vec = {
		fault_i.addr_range_fault,
		fault_i.block_alignment_fault,
		fault_i.blocklen_fault,
		fault_i.erase_order_fault,
		fault_i.erase_group_fault,
		fault_i.protected_write_fault,
		1'b0,
		fault_i.lock_unlock_fault,
		2'b00,
		fault_i.ecc_fail,
		fault_i.internal_ctrl_fault,
		fault_i.generic_fault,
		2'b00,
		fault_i.id_reg_overwrite_fault,
		fault_i.erase_skip,
		1'b0,
		cancel
	} & READ_CLR_MASK;

	// Set wins over clear so an event in the read cycle survives
	assign flags_next = set_vec |
		(status_read_i ? {FLAG_W{1'b0}} : flags_reg);

	// ************************************************************
	// Per-command flags
	// ************************************************************
	// A valid command publishes its own verdict; the next valid command
	// replaces that verdict, so the flags track the latest command.
	wire cmd_ok = cmd_i.valid && !cmd_i.crc_bad;
	assign crc_next = cmd_i.valid ? cmd_i.crc_bad : crc_reg;
	assign ill_next = cmd_ok ? cmd_i.illegal :
		(cmd_i.valid ? 1'b0 : ill_reg);

	// ************************************************************
	// Word assembly
	// ************************************************************
	always_comb begin
		status_next = STATUS_RST;
		status_next[31:FLAG_LSB] = flags_reg;
		status_next[BIT_LOCKED]  = cond_i.locked_flag;
		status_next[BIT_ECC_OFF] = cond_i.ecc_off;
		status_next[BIT_CMD_CRC] = crc_reg;
		status_next[BIT_ILLEGAL_CMD] = ill_reg;
		status_next[BIT_RSVD_HI] = 1'b0;
		status_next[BIT_RSVD_LO] = 1'b0;
	end

	assign status_o = status_reg;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_reg    <= FLAGS_RST;
			crc_reg      <= 1'b0;
			ill_reg      <= 1'b0;
			status_reg   <= STATUS_RST;
		end else begin
			flags_reg    <= flags_next;
			crc_reg      <= crc_next;
			ill_reg      <= ill_next;
			status_reg   <= status_next;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	property p_range_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.addr_range_fault |-> ##2 status_o[BIT_ADDR_RANGE];
	endproperty
	a_range_set: assert property (p_range_set)
		else $error("Range fault not reported");

	property p_align_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.block_alignment_fault |->
			##2 status_o[BIT_BLOCK_ALIGN];
	endproperty
	a_align_set: assert property (p_align_set)
		else $error("Alignment fault not reported");

	property p_blocklen_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.blocklen_fault |->
			##2 status_o[BIT_BLOCKLEN];
	endproperty
	a_blocklen_set: assert property (p_blocklen_set)
		else $error("Block length fault not reported");

	property p_erase_order_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.erase_order_fault |->
			##2 status_o[BIT_ERASE_ORDER];
	endproperty
	a_erase_order_set: assert property (p_erase_order_set)
		else $error("Erase order fault not reported");

	property p_erase_group_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.erase_group_fault |->
			##2 status_o[BIT_ERASE_GROUP];
	endproperty
	a_erase_group_set: assert property (p_erase_group_set)
		else $error("Erase group fault not reported");

	property p_prot_write_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.protected_write_fault |->
			##2 status_o[BIT_PROT_WRITE];
	endproperty
	a_prot_write_set: assert property (p_prot_write_set)
		else $error("Protected write fault not reported");

	property p_lock_fail_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.lock_unlock_fault |->
			##2 status_o[BIT_LOCK_FAIL];
	endproperty
	a_lock_fail_set: assert property (p_lock_fail_set)
		else $error("Lock fault not reported");

	property p_ecc_fail_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.ecc_fail |->
			##2 status_o[BIT_ECC_FAIL];
	endproperty
	a_ecc_fail_set: assert property (p_ecc_fail_set)
		else $error("Correction failure not reported");

	property p_internal_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.internal_ctrl_fault |->
			##2 status_o[BIT_INTERNAL_CTRL];
	endproperty
	a_internal_set: assert property (p_internal_set)
		else $error("Internal fault not reported");

	property p_generic_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.generic_fault |->
			##2 status_o[BIT_GENERIC];
	endproperty
	a_generic_set: assert property (p_generic_set)
		else $error("Generic fault not reported");

	property p_overwrite_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.id_reg_overwrite_fault |->
			##2 status_o[BIT_ID_OVERWRITE];
	endproperty
	a_overwrite_set: assert property (p_overwrite_set)
		else $error("Overwrite fault not reported");

	property p_erase_skip_set;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fault_i.erase_skip |->
			##2 status_o[BIT_ERASE_SKIP];
	endproperty
	a_erase_skip_set: assert property (p_erase_skip_set)
		else $error("Erase skip not reported");

	// The detector pulse lands two cycles before the word shows it
	property p_cancel_flag;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		cancel |->
			##2 status_o[BIT_ERASE_CANCEL];
	endproperty
	a_cancel_flag: assert property (p_cancel_flag)
		else $error("Cancel pulse not latched");

	property p_read_clears;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(status_read_i && !fault_i.generic_fault) |-> ##2
			!status_o[BIT_GENERIC];
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("Generic error survived read");

	property p_sticky;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(flags_reg[BIT_BLOCKLEN-FLAG_LSB] && !status_read_i) |=>
			flags_reg[BIT_BLOCKLEN-FLAG_LSB];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("Block length flag dropped without read");

	property p_lock_mirror;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		##1 status_o[BIT_LOCKED] == $past(cond_i.locked_flag);
	endproperty
	a_lock_mirror: assert property (p_lock_mirror)
		else $error("Lock bit does not follow lock state");

	property p_ecc_mirror;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		##1 status_o[BIT_ECC_OFF] == $past(cond_i.ecc_off);
	endproperty
	a_ecc_mirror: assert property (p_ecc_mirror)
		else $error("Correction bit does not follow state");

	property p_reserved;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		status_o[BIT_RSVD_HI:BIT_RSVD_LO] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("Reserved bits set");

	sequence s_bad_crc;
		cmd_i.valid && cmd_i.crc_bad;
	endsequence
	sequence s_good_cmd;
		cmd_i.valid && !cmd_i.crc_bad;
	endsequence
	property p_crc_flag;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		s_bad_crc |-> ##2 status_o[BIT_CMD_CRC];
	endproperty
	a_crc_flag: assert property (p_crc_flag)
		else $error("CRC error not reported");

	property p_crc_clear;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		s_good_cmd |-> ##2 !status_o[BIT_CMD_CRC];
	endproperty
	a_crc_clear: assert property (p_crc_clear)
		else $error("CRC flag not cleared by next command");

	property p_crc_hold;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!cmd_i.valid |-> ##2 $stable(status_o[BIT_CMD_CRC]);
	endproperty
	a_crc_hold: assert property (p_crc_hold)
		else $error("CRC flag changed without a command");

	property p_ill_hold;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!cmd_i.valid |-> ##2 $stable(status_o[BIT_ILLEGAL_CMD]);
	endproperty
	a_ill_hold: assert property (p_ill_hold)
		else $error("Illegal flag changed without a command");

	property p_illegal_flag;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(cmd_i.valid && !cmd_i.crc_bad && cmd_i.illegal) |->
			##2 status_o[BIT_ILLEGAL_CMD];
	endproperty
	a_illegal_flag: assert property (p_illegal_flag)
		else $error("Illegal command not reported");

	property p_cancel;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(cmd_i.valid && !cmd_i.illegal && cmd_i.index == CMD_ERASE_START)
		##1 (!cmd_i.valid)[*1] ##1
		(cmd_i.valid && cmd_i.index == 6'h11) |-> ##3
			status_o[BIT_ERASE_CANCEL];
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("Erase cancel not reported");

endmodule
